// >>> design/perf_index_table.sv
// Per-state performance index table with two registered read ports
`timescale 1ns/10ps
module perf_index_table (
  input  wire logic                              clock,
  input  wire logic                              srst,
  input  wire logic                              wr_en,
  input  wire logic [pstate_pkg::STATE_W-1:0]    wr_addr,
  input  wire logic [pstate_pkg::INDEX_W-1:0]    wr_data,
  input  wire logic [pstate_pkg::STATE_W-1:0]    rd_addr_a,
  output logic      [pstate_pkg::INDEX_W-1:0]    rd_data_a,
  input  wire logic [pstate_pkg::STATE_W-1:0]    rd_addr_b,
  output logic      [pstate_pkg::INDEX_W-1:0]    rd_data_b
);

  logic [pstate_pkg::INDEX_W-1:0] mem_q [pstate_pkg::NUM_STATES];

  for (genvar i = 0; i < pstate_pkg::NUM_STATES; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (srst) begin
        mem_q[i] <= pstate_pkg::INDEX_P0 - pstate_pkg::INDEX_W'(i * pstate_pkg::INDEX_STEP);
      end else if (wr_en && (wr_addr == pstate_pkg::STATE_W'(i))) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem_q[rd_addr_a];
      rd_data_b <= mem_q[rd_addr_b];
    end
  end

endmodule : perf_index_table

// >>> design/pstate_pkg.sv
// Constants, register map and carrier types for the performance-state controller
package pstate_pkg;

  // Widths and counts
  localparam int STATE_W    = 4;
  localparam int NUM_STATES = 16;
  localparam int INDEX_W    = 8;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int TIMER_W    = 8;
  localparam int SUM_W      = 40;
  localparam int COUNT_W    = 32;
  localparam int RESULT_W   = 16;
  localparam int DIV_W      = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] REQ_OFS     = 8'h04;
  localparam logic [ADDR_W-1:0] QUERY_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] RESULT_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] TABLE_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] FEATURE_OFS = 8'h18;

  // Field positions
  localparam int CTRL_LSB        = 0;
  localparam int REQ_STATE_LSB   = 0;
  localparam int QUERY_TYPE_LSB  = 0;
  localparam int TABLE_ENTRY_LSB = 0;
  localparam int TABLE_VALUE_LSB = 8;
  localparam int RESULT_VALID_BIT = 31;

  // Query type codes
  localparam logic [1:0] QUERY_REQUESTED = 2'h0;
  localparam logic [1:0] QUERY_AVG_RESET = 2'h1;
  localparam logic [1:0] QUERY_AVG       = 2'h2;
  localparam logic [1:0] QUERY_DOMAIN    = 2'h3;

  typedef enum logic [1:0] {
    DOMAIN_SW,
    DOMAIN_HW,
    DOMAIN_INDEP
  } domain_t;

  typedef struct packed {
    logic    preempt;
    domain_t domain;
    logic    var_en;
    logic    pst_en;
  } ctrl_t;

  localparam int    CTRL_W     = $bits(ctrl_t);
  localparam ctrl_t CTRL_RESET = 5'h11;

  typedef struct packed {
    logic               cap;
    logic               thermal;
    logic               query_busy;
    logic               busy;
    logic               last_ok;
    logic               last_valid;
    logic [STATE_W-1:0] op;
    logic [STATE_W-1:0] local_st;
    logic [STATE_W-1:0] domain_st;
    logic [STATE_W-1:0] requested;
  } status_t;

  localparam int STATUS_W = $bits(status_t);

  // Index table reset contents: P0 is 100, 5 lower per state
  localparam logic [INDEX_W-1:0] INDEX_P0   = 8'h64;
  localparam logic [INDEX_W-1:0] INDEX_STEP = 8'h05;

  // Timing
  localparam int CLOCK_MHZ         = 250;
  localparam int TRANSITION_NS     = 400;
  localparam int STEP_NS           = 100;
  localparam int TRANSITION_CYCLES = (TRANSITION_NS * CLOCK_MHZ + 999) / 1000;
  localparam int STEP_CYCLES       = (STEP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int DIV_STEPS         = SUM_W;

endpackage : pstate_pkg

// >>> design/pstate_request_perf_index.sv
// Performance-state request handling, domain coordination and performance index
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps

module pstate_request_perf_index #(
  parameter logic PSTATE_SUPPORTED  = 1'b1,
  parameter logic VARFREQ_SUPPORTED = 1'b1
) (
  input  wire logic                             clock,
  input  wire logic                             srst,
  input  wire logic [pstate_pkg::ADDR_W-1:0]    addr,
  input  wire logic [pstate_pkg::DATA_W-1:0]    wdata,
  input  wire logic                             wr_en,
  input  wire logic                             rd_en,
  output logic      [pstate_pkg::DATA_W-1:0]    rdata,
  input  wire logic                             power_cap_active,
  input  wire logic [pstate_pkg::STATE_W-1:0]   cap_state,
  input  wire logic                             thermal_protect,
  input  wire logic [pstate_pkg::STATE_W-1:0]   peer_min_state,
  input  wire logic [pstate_pkg::INDEX_W-1:0]   freq_boost,
  output logic      [pstate_pkg::STATE_W-1:0]   requested_state,
  output logic      [pstate_pkg::STATE_W-1:0]   domain_state,
  output logic      [pstate_pkg::STATE_W-1:0]   local_state,
  output logic      [pstate_pkg::STATE_W-1:0]   operating_state,
  output logic                                  transition_busy
);

  typedef enum logic [1:0] {
    Q_IDLE,
    Q_LOOKUP,
    Q_DIVIDE
  } query_state_t;

  pstate_pkg::ctrl_t              ctrl_q;
  logic [pstate_pkg::STATE_W-1:0] req_state_q;
  logic [pstate_pkg::STATE_W-1:0] domain_state_q;
  logic [pstate_pkg::STATE_W-1:0] local_state_q;
  logic [pstate_pkg::STATE_W-1:0] op_state_q;
  logic [pstate_pkg::TIMER_W-1:0] timer_q;
  logic [pstate_pkg::TIMER_W-1:0] step_cnt_q;
  logic                           last_valid_q;
  logic                           last_ok_q;
  logic [pstate_pkg::SUM_W-1:0]   sum_q;
  logic [pstate_pkg::COUNT_W-1:0] count_q;
  query_state_t                   qstate_q;
  logic [pstate_pkg::SUM_W-1:0]   dividend_q;
  logic [pstate_pkg::COUNT_W-1:0] divisor_q;
  logic [pstate_pkg::COUNT_W-1:0] rem_q;
  logic [pstate_pkg::SUM_W-1:0]   quo_q;
  logic [pstate_pkg::DIV_W-1:0]   div_cnt_q;
  logic [pstate_pkg::RESULT_W-1:0] result_q;
  logic                           result_valid_q;
  logic [pstate_pkg::DATA_W-1:0]  rdata_q;

  logic                           wr_ctrl;
  logic                           req_fire;
  logic                           query_fire;
  logic                           table_wr;
  logic                           busy;
  logic                           accept;
  logic                           step_tick;
  logic [pstate_pkg::STATE_W-1:0] new_state;
  logic [1:0]                     query_type;
  logic [pstate_pkg::STATE_W-1:0] effective_state;
  logic [pstate_pkg::STATE_W-1:0] capped_state;
  logic [pstate_pkg::STATE_W-1:0] lookup_addr;
  logic [pstate_pkg::INDEX_W-1:0] idx_op;
  logic [pstate_pkg::INDEX_W-1:0] idx_lookup;
  logic [pstate_pkg::INDEX_W-1:0] boost_eff;
  logic [pstate_pkg::INDEX_W:0]   sample;
  logic                           reset_measure;
  logic [pstate_pkg::COUNT_W:0]   trial;
  logic                           trial_ge;
  pstate_pkg::status_t            status;

  // Bus decode
  assign wr_ctrl    = wr_en && (addr == pstate_pkg::CTRL_OFS);
  assign req_fire   = wr_en && (addr == pstate_pkg::REQ_OFS);
  assign query_fire = wr_en && (addr == pstate_pkg::QUERY_OFS) && (qstate_q == Q_IDLE);
  assign table_wr   = wr_en && (addr == pstate_pkg::TABLE_OFS);
  assign new_state  = wdata[pstate_pkg::REQ_STATE_LSB +: pstate_pkg::STATE_W];
  assign query_type = wdata[pstate_pkg::QUERY_TYPE_LSB +: 2];

  assign busy = (timer_q != '0);

  // Cap has no say in acceptance; only enable, thermal and policy do
  assign accept = req_fire && ctrl_q.pst_en && PSTATE_SUPPORTED && !thermal_protect
                  && (!busy || ctrl_q.preempt);

  // Control register
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q <= pstate_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pstate_pkg::ctrl_t'(wdata[pstate_pkg::CTRL_LSB +: pstate_pkg::CTRL_W]);
    end
  end

  // Requested state and last outcome
  always_ff @(posedge clock) begin
    if (srst) begin
      req_state_q  <= '0;
      last_valid_q <= 1'b0;
      last_ok_q    <= 1'b0;
    end else if (req_fire) begin
      last_valid_q <= 1'b1;
      last_ok_q    <= accept;
      if (accept) begin
        req_state_q <= new_state;
      end
    end
  end

  // Transition timer; preemption restarts it
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_q <= '0;
    end else if (accept) begin
      timer_q <= pstate_pkg::TIMER_W'(pstate_pkg::TRANSITION_CYCLES);
    end else if (busy) begin
      timer_q <= timer_q - pstate_pkg::TIMER_W'(1);
    end
  end

  // Step enable for gradual local adjustment
  always_ff @(posedge clock) begin
    if (srst) begin
      step_cnt_q <= '0;
    end else if (step_tick) begin
      step_cnt_q <= pstate_pkg::TIMER_W'(pstate_pkg::STEP_CYCLES - 1);
    end else begin
      step_cnt_q <= step_cnt_q - pstate_pkg::TIMER_W'(1);
    end
  end

  assign step_tick = (step_cnt_q == '0);

  // Shared domain parameters
  always_ff @(posedge clock) begin
    if (srst) begin
      domain_state_q <= '0;
    end else begin
      case (ctrl_q.domain)
        pstate_pkg::DOMAIN_HW: begin
          domain_state_q <= (req_state_q < peer_min_state) ? req_state_q : peer_min_state;
        end
        pstate_pkg::DOMAIN_SW: begin
          if (accept) begin
            domain_state_q <= new_state;
          end
        end
        default: begin
          if (accept) begin
            domain_state_q <= new_state;
          end
        end
      endcase
    end
  end

  // Local parameters
  always_ff @(posedge clock) begin
    if (srst) begin
      local_state_q <= '0;
    end else if (ctrl_q.domain == pstate_pkg::DOMAIN_HW) begin
      if (step_tick && (local_state_q < req_state_q)) begin
        local_state_q <= local_state_q + pstate_pkg::STATE_W'(1);
      end else if (step_tick && (local_state_q > req_state_q)) begin
        local_state_q <= local_state_q - pstate_pkg::STATE_W'(1);
      end
    end else if (accept) begin
      local_state_q <= new_state;
    end
  end

  // Slowest of domain and local; cap may only slow it further
  assign effective_state = (domain_state_q > local_state_q) ? domain_state_q : local_state_q;
  assign capped_state    = (power_cap_active && (cap_state > effective_state)) ?
                           cap_state : effective_state;

  always_ff @(posedge clock) begin
    if (srst) begin
      op_state_q <= '0;
    end else begin
      op_state_q <= capped_state;
    end
  end

  // Index table: port a follows operating state, port b serves lookups
  assign lookup_addr = (query_type == pstate_pkg::QUERY_REQUESTED) ?
                       req_state_q : domain_state_q;

  perf_index_table u_table (
    .clock     (clock),
    .srst      (srst),
    .wr_en     (table_wr),
    .wr_addr   (wdata[pstate_pkg::TABLE_ENTRY_LSB +: pstate_pkg::STATE_W]),
    .wr_data   (wdata[pstate_pkg::TABLE_VALUE_LSB +: pstate_pkg::INDEX_W]),
    .rd_addr_a (op_state_q),
    .rd_data_a (idx_op),
    .rd_addr_b (lookup_addr),
    .rd_data_b (idx_lookup)
  );

  // Accumulator of capped index plus boost, one sample per cycle while pst_en is set
  assign boost_eff = (ctrl_q.var_en && VARFREQ_SUPPORTED) ? freq_boost : '0;
  assign sample    = {1'b0, idx_op} + {1'b0, boost_eff};
  assign reset_measure = query_fire && (query_type == pstate_pkg::QUERY_AVG_RESET);

  always_ff @(posedge clock) begin
    if (srst) begin
      sum_q   <= '0;
      count_q <= '0;
    end else if (reset_measure) begin
      sum_q   <= '0;
      count_q <= '0;
    end else if (ctrl_q.pst_en) begin
      sum_q   <= sum_q + pstate_pkg::SUM_W'(sample);
      count_q <= count_q + pstate_pkg::COUNT_W'(1);
    end
  end

  // Restoring divider step
  assign trial    = {rem_q, dividend_q[pstate_pkg::SUM_W-1]};
  assign trial_ge = (trial >= {1'b0, divisor_q});

  // Query sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      qstate_q <= Q_IDLE;
    end else begin
      case (qstate_q)
        Q_IDLE: begin
          if (query_fire && ((query_type == pstate_pkg::QUERY_REQUESTED) ||
                             (query_type == pstate_pkg::QUERY_DOMAIN))) begin
            qstate_q <= Q_LOOKUP;
          end else if (query_fire) begin
            qstate_q <= Q_DIVIDE;
          end
        end
        Q_LOOKUP: begin
          qstate_q <= Q_IDLE;
        end
        Q_DIVIDE: begin
          if (div_cnt_q == '0) begin
            qstate_q <= Q_IDLE;
          end
        end
        default: begin
          qstate_q <= Q_IDLE;
        end
      endcase
    end
  end

  // Divider datapath; sum and count are snapshot before any reset
  always_ff @(posedge clock) begin
    if (srst) begin
      dividend_q <= '0;
      divisor_q  <= '0;
      rem_q      <= '0;
      quo_q      <= '0;
      div_cnt_q  <= '0;
    end else if (query_fire) begin
      dividend_q <= sum_q;
      divisor_q  <= count_q;
      rem_q      <= '0;
      quo_q      <= '0;
      div_cnt_q  <= pstate_pkg::DIV_W'(pstate_pkg::DIV_STEPS);
    end else if ((qstate_q == Q_DIVIDE) && (div_cnt_q != '0)) begin
      dividend_q <= {dividend_q[pstate_pkg::SUM_W-2:0], 1'b0};
      rem_q      <= trial_ge ? pstate_pkg::COUNT_W'(trial - {1'b0, divisor_q}) :
                               trial[pstate_pkg::COUNT_W-1:0];
      quo_q      <= {quo_q[pstate_pkg::SUM_W-2:0], trial_ge};
      div_cnt_q  <= div_cnt_q - pstate_pkg::DIV_W'(1);
    end
  end

  // Query result
  always_ff @(posedge clock) begin
    if (srst) begin
      result_q       <= '0;
      result_valid_q <= 1'b0;
    end else if (query_fire) begin
      result_valid_q <= 1'b0;
    end else if (qstate_q == Q_LOOKUP) begin
      result_q       <= pstate_pkg::RESULT_W'(idx_lookup);
      result_valid_q <= 1'b1;
    end else if ((qstate_q == Q_DIVIDE) && (div_cnt_q == '0)) begin
      result_valid_q <= 1'b1;
      if (divisor_q == '0) begin
        result_q <= '0;
      end else if (|quo_q[pstate_pkg::SUM_W-1:pstate_pkg::RESULT_W]) begin
        result_q <= '1;
      end else begin
        result_q <= quo_q[pstate_pkg::RESULT_W-1:0];
      end
    end
  end

  // Status shows requested, domain and local states and the capped operating state
  always_comb begin
    status            = '0;
    status.cap        = power_cap_active;
    status.thermal    = thermal_protect;
    status.query_busy = (qstate_q != Q_IDLE);
    status.busy       = busy;
    status.last_ok    = last_ok_q;
    status.last_valid = last_valid_q;
    status.op         = op_state_q;
    status.local_st   = local_state_q;
    status.domain_st  = domain_state_q;
    status.requested  = req_state_q;
  end

  // Read data, valid only the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (rd_en) begin
      case (addr)
        pstate_pkg::CTRL_OFS:    rdata_q <= pstate_pkg::DATA_W'(ctrl_q);
        pstate_pkg::REQ_OFS:     rdata_q <= pstate_pkg::DATA_W'(req_state_q);
        pstate_pkg::RESULT_OFS: begin
          rdata_q                               <= pstate_pkg::DATA_W'(result_q);
          rdata_q[pstate_pkg::RESULT_VALID_BIT] <= result_valid_q;
        end
        pstate_pkg::STATUS_OFS:  rdata_q <= pstate_pkg::DATA_W'(status);
        pstate_pkg::FEATURE_OFS: rdata_q <= pstate_pkg::DATA_W'({VARFREQ_SUPPORTED,
                                                                 PSTATE_SUPPORTED});
        default:                 rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata           = rdata_q;
  assign requested_state = req_state_q;
  assign domain_state    = domain_state_q;
  assign local_state     = local_state_q;
  assign operating_state = op_state_q;
  assign transition_busy = busy;

endmodule : pstate_request_perf_index

// >>> testbench/fw_model.sv
// Firmware-side bus master issuing state requests and queries
`timescale 1ns/10ps
module fw_model (
  input  wire logic        clock,
  input  wire logic [31:0] rdata,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr_en,
  output logic             rd_en
);
  initial begin
    addr  = 8'h00;
    wdata = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Retries once after the transition time
  task automatic request(input logic [3:0] s, output logic ok);
    logic [31:0] st;
    wr(pstate_pkg::REQ_OFS, {28'h0, s});
    rd(pstate_pkg::STATUS_OFS, st);
    if (!st[17]) begin
      repeat (pstate_pkg::TRANSITION_CYCLES) @(posedge clock);
      wr(pstate_pkg::REQ_OFS, {28'h0, s});
      rd(pstate_pkg::STATUS_OFS, st);
    end
    ok = st[17];
  endtask : request
  task automatic query(input logic [1:0] t, output logic [15:0] r);
    logic [31:0] v;
    int          i;
    wr(pstate_pkg::QUERY_OFS, {30'h0, t});
    v = 32'h00000000;
    for (i = 0; i < 60 && v[pstate_pkg::RESULT_VALID_BIT] !== 1'b1; i++) rd(pstate_pkg::RESULT_OFS, v);
    r = v[15:0];
  endtask : query
endmodule : fw_model

// >>> testbench/pstate_checker.sv
// Port-level assertions for the performance-state controller
`timescale 1ns/10ps
module pstate_checker (
  input wire logic                           clock,
  input wire logic                           srst,
  input wire logic [pstate_pkg::ADDR_W-1:0]  addr,
  input wire logic [pstate_pkg::DATA_W-1:0]  wdata,
  input wire logic                           wr_en,
  input wire logic                           rd_en,
  input wire logic [pstate_pkg::DATA_W-1:0]  rdata,
  input wire logic                           power_cap_active,
  input wire logic [pstate_pkg::STATE_W-1:0] cap_state,
  input wire logic                           thermal_protect,
  input wire logic [pstate_pkg::STATE_W-1:0] peer_min_state,
  input wire logic [pstate_pkg::INDEX_W-1:0] freq_boost,
  input wire logic [pstate_pkg::STATE_W-1:0] requested_state,
  input wire logic [pstate_pkg::STATE_W-1:0] domain_state,
  input wire logic [pstate_pkg::STATE_W-1:0] local_state,
  input wire logic [pstate_pkg::STATE_W-1:0] operating_state,
  input wire logic                           transition_busy
);
  pstate_pkg::ctrl_t ctrl_q;
  logic              hw_d1_q;
  logic              req_wr;
  logic              allowed;
  logic              is_sw;
  logic              is_hw;
  logic [3:0]        min_st;
  logic [3:0]        max_st;

  // Control register mirrored from bus writes
  always_ff @(posedge clock) begin
    if (srst) ctrl_q <= pstate_pkg::CTRL_RESET;
    else if (wr_en && addr == pstate_pkg::CTRL_OFS) ctrl_q <= pstate_pkg::ctrl_t'(wdata[4:0]);
  end
  always_ff @(posedge clock) begin
    hw_d1_q <= srst ? 1'b0 : is_hw;
  end
  assign req_wr  = wr_en && addr == pstate_pkg::REQ_OFS;
  assign allowed = ctrl_q.pst_en && !thermal_protect && (!transition_busy || ctrl_q.preempt);
  assign is_sw   = ctrl_q.domain == pstate_pkg::DOMAIN_SW;
  assign is_hw   = ctrl_q.domain == pstate_pkg::DOMAIN_HW;
  assign min_st  = requested_state < peer_min_state ? requested_state : peer_min_state;
  assign max_st  = domain_state > local_state ? domain_state : local_state;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_accept;
    req_wr && allowed;
  endsequence
  sequence s_taken;
    requested_state == $past(wdata[3:0]) && transition_busy;
  endsequence

  property p_accept_sw;
    s_accept ##0 is_sw |=> s_taken ##0 domain_state == $past(wdata[3:0]);
  endproperty
  a_accept_sw: assert property (p_accept_sw) else $error("shared state not moved");
  property p_accept_indep;
    s_accept ##0 (!is_sw && !is_hw) |=> s_taken ##0 domain_state == $past(wdata[3:0]);
  endproperty
  a_accept_indep: assert property (p_accept_indep) else $error("own state not moved");
  property p_preempt;
    s_accept ##0 transition_busy |=> s_taken;
  endproperty
  a_preempt: assert property (p_preempt) else $error("running change not replaced");
  property p_no_preempt;
    req_wr && transition_busy && !ctrl_q.preempt |=> $stable(requested_state);
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("busy request taken");
  property p_cap_floor;
    power_cap_active |=> operating_state >= $past(cap_state);
  endproperty
  a_cap_floor: assert property (p_cap_floor) else $error("cap not applied");
  property p_cap_release;
    !power_cap_active |=> operating_state == $past(max_st);
  endproperty
  a_cap_release: assert property (p_cap_release) else $error("uncapped state wrong");
  property p_hw_domain;
    is_hw && hw_d1_q && $stable(requested_state) && $stable(peer_min_state) |-> domain_state == min_st;
  endproperty
  a_hw_domain: assert property (p_hw_domain) else $error("domain not fastest");
  property p_busy_cause;
    $rose(transition_busy) |-> $past(req_wr);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("change without request");
endmodule : pstate_checker

bind pstate_request_perf_index pstate_checker u_pstate_checker (
  .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .power_cap_active(power_cap_active), .cap_state(cap_state),
  .thermal_protect(thermal_protect), .peer_min_state(peer_min_state), .freq_boost(freq_boost),
  .requested_state(requested_state), .domain_state(domain_state), .local_state(local_state),
  .operating_state(operating_state), .transition_busy(transition_busy)
);

// >>> testbench/test_pstate_request_perf_index.sv
// Self-checking bench for the performance-state controller
`timescale 1ns/10ps
module test_pstate_request_perf_index;
  logic        clock;
  logic        srst = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        power_cap_active = 1'b0;
  logic [3:0]  cap_state = 4'h0;
  logic        thermal_protect = 1'b0;
  logic [3:0]  peer_min_state = 4'hf;
  logic [7:0]  freq_boost = 8'h00;
  logic [3:0]  requested_state;
  logic [3:0]  domain_state;
  logic [3:0]  local_state;
  logic [3:0]  operating_state;
  logic        transition_busy;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  pstate_request_perf_index u_pstate_request_perf_index (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .power_cap_active(power_cap_active), .cap_state(cap_state),
    .thermal_protect(thermal_protect), .peer_min_state(peer_min_state), .freq_boost(freq_boost),
    .requested_state(requested_state), .domain_state(domain_state), .local_state(local_state),
    .operating_state(operating_state), .transition_busy(transition_busy)
  );
  fw_model u_fw_model (
    .clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [31:0] idx(input int s);
    return {24'h0, pstate_pkg::INDEX_P0 - pstate_pkg::INDEX_STEP * 8'(s)};
  endfunction : idx
  task automatic close_out();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_fw_model.wr(a, d);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    u_fw_model.rd(a, v);
    chk(what, v & m, e);
  endtask : rd_chk
  task automatic idle();
    for (int i = 0; i < 300 && transition_busy !== 1'b0; i++) cyc(1);
  endtask : idle
  task automatic avg_chk(input string what, input logic [31:0] e);
    logic [15:0] r;
    u_fw_model.query(pstate_pkg::QUERY_AVG_RESET, r);
    cyc(100);
    u_fw_model.query(pstate_pkg::QUERY_AVG, r);
    chk(what, {16'h0, r}, e);
  endtask : avg_chk

  task automatic t_reset();
    rd_chk("ctrl reset", pstate_pkg::CTRL_OFS, 32'hffffffff, 32'h00000011);
    wr(pstate_pkg::FEATURE_OFS, 32'h00000000);
    rd_chk("feature", pstate_pkg::FEATURE_OFS, 32'hffffffff, 32'h00000003);
    rd_chk("unmapped", 8'h1c, 32'hffffffff, 32'h00000000);
    rd_chk("status reset", pstate_pkg::STATUS_OFS, 32'hffffffff, 32'h00000000);
    wr(pstate_pkg::CTRL_OFS, 32'h00000013);
    rd_chk("var enable", pstate_pkg::CTRL_OFS, 32'hffffffff, 32'h00000013);
    wr(pstate_pkg::CTRL_OFS, 32'h00000011);
  endtask : t_reset
  task automatic t_preempt();
    wr(pstate_pkg::REQ_OFS, 32'h00000004);
    wr(pstate_pkg::REQ_OFS, 32'h0000000f);
    rd_chk("preempt", pstate_pkg::STATUS_OFS, 32'h0006000f, 32'h0006000f);
  endtask : t_preempt
  task automatic t_no_preempt();
    logic ok;
    idle();
    wr(pstate_pkg::CTRL_OFS, 32'h00000001);
    wr(pstate_pkg::REQ_OFS, 32'h00000002);
    wr(pstate_pkg::REQ_OFS, 32'h00000005);
    rd_chk("busy reject", pstate_pkg::STATUS_OFS, 32'h0002000f, 32'h00000002);
    u_fw_model.request(4'h5, ok);
    chk("retry", {31'h0, ok}, 32'h00000001);
    rd_chk("retry state", pstate_pkg::REQ_OFS, 32'h0000000f, 32'h00000005);
    wr(pstate_pkg::CTRL_OFS, 32'h00000011);
  endtask : t_no_preempt
  task automatic t_thermal();
    idle();
    @(posedge clock);
    thermal_protect <= 1'b1;
    wr(pstate_pkg::REQ_OFS, 32'h00000007);
    rd_chk("thermal", pstate_pkg::STATUS_OFS, 32'h0006000f, 32'h00000005);
    @(posedge clock);
    thermal_protect <= 1'b0;
    wr(pstate_pkg::CTRL_OFS, 32'h00000010);
    wr(pstate_pkg::REQ_OFS, 32'h00000007);
    rd_chk("disabled", pstate_pkg::STATUS_OFS, 32'h0002000f, 32'h00000005);
    wr(pstate_pkg::CTRL_OFS, 32'h00000011);
  endtask : t_thermal
  task automatic t_cap();
    logic [15:0] r;
    idle();
    @(posedge clock);
    cap_state <= 4'h9;
    power_cap_active <= 1'b1;
    wr(pstate_pkg::REQ_OFS, 32'h00000002);
    rd_chk("cap accept", pstate_pkg::STATUS_OFS, 32'h0002000f, 32'h00020002);
    chk("cap op", {28'h0, operating_state}, 32'h00000009);
    for (int i = 0; i < 4; i += 3) begin
      u_fw_model.query(2'(i), r);
      chk("cap query", {16'h0, r}, idx(2));
    end
    @(posedge clock);
    power_cap_active <= 1'b0;
    cyc(3);
    chk("release op", {28'h0, operating_state}, 32'h00000002);
    wr(pstate_pkg::TABLE_OFS, 32'h00005002);
    u_fw_model.query(2'h0, r);
    chk("table", {16'h0, r}, 32'h00000050);
  endtask : t_cap
  task automatic t_hw();
    idle();
    @(posedge clock);
    peer_min_state <= 4'h1;
    wr(pstate_pkg::CTRL_OFS, 32'h00000015);
    wr(pstate_pkg::REQ_OFS, 32'h00000003);
    cyc(3);
    chk("hw domain", {28'h0, domain_state}, 32'h00000001);
    for (int i = 0; i < 300 && local_state !== 4'h3; i++) cyc(1);
    chk("hw local", {28'h0, local_state}, 32'h00000003);
    @(posedge clock);
    peer_min_state <= 4'h7;
    cyc(3);
    chk("hw follow", {28'h0, domain_state}, 32'h00000003);
    avg_chk("hw avg", idx(3));
  endtask : t_hw
  task automatic t_avg();
    wr(pstate_pkg::CTRL_OFS, 32'h00000019);
    wr(pstate_pkg::REQ_OFS, 32'h00000000);
    avg_chk("indep avg", idx(0));
    @(posedge clock);
    cap_state <= 4'h4;
    power_cap_active <= 1'b1;
    avg_chk("capped avg", idx(4));
    @(posedge clock);
    power_cap_active <= 1'b0;
    freq_boost <= 8'h14;
    wr(pstate_pkg::CTRL_OFS, 32'h0000001b);
    avg_chk("boost avg", idx(0) + 32'h00000014);
  endtask : t_avg

  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_preempt();
    t_no_preempt();
    t_thermal();
    t_cap();
    t_hw();
    t_avg();
    close_out();
  end
endmodule : test_pstate_request_perf_index
